// [cssx_consts.svh]
// Summary of operation
// - Compare immediate sets five flags, one cycle
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Flag set branches to PC plus offset plus one
// - Flag clear branches to PC plus offset plus one
`ifndef CSSX_CONSTS_SVH
`define CSSX_CONSTS_SVH

// APB register byte offsets
`define CSSX_OFS_CTRL 8'h00
`define CSSX_OFS_STATUS 8'h04
`define CSSX_OFS_PC 8'h08
`define CSSX_OFS_INFO 8'h0C

// Field positions
`define CSSX_CTRL_ENABLE 0
`define CSSX_FLAG_C 0
`define CSSX_FLAG_Z 1
`define CSSX_FLAG_N 2
`define CSSX_FLAG_V 3
`define CSSX_FLAG_H 5
`define CSSX_INFO_BUSY 2

// Reset values
`define CSSX_RST_ENABLE 1'b1
`define CSSX_RST_STATUS 8'h00
`define CSSX_RST_PC 16'h0000

// Cycle counts of one instruction
`define CSSX_CYC_ONE 2'd1
`define CSSX_CYC_TWO 2'd2
`define CSSX_CYC_THREE 2'd3

// Program counter steps
`define CSSX_PC_STEP 16'h0001
`define CSSX_PC_SKIP1 16'h0002
`define CSSX_PC_SKIP2 16'h0003

`endif

// [cssx_pkg.sv]
package cssx_pkg;

	// Instruction classes handled by this unit
	typedef enum logic [2:0] {
		cssx_compare_immediate,
		cssx_skip_if_reg_bit_clear,
		cssx_skip_if_reg_bit_set,
		cssx_skip_if_io_bit_clear,
		cssx_skip_if_io_bit_set,
		cssx_branch_if_flag_set,
		cssx_branch_if_flag_clear
	} cssx_op_type;

	// One issued instruction with operands already fetched by the core
	typedef struct packed {
		cssx_op_type op;
		logic [7:0] reg_value;     // Destination or source_operand register value
		logic [7:0] immediate;     // Compare constant
		logic [2:0] bit_sel;       // Bit index, or status_register flag index
		logic [7:0] io_value;      // Value read from the addressed I/O location
		logic [6:0] offset;        // Signed branch offset in words
		logic next_two_word;       // Following instruction is two words long
	} cssx_issue_type;

	// Whole state of the unit
	typedef struct packed {
		logic enable;
		logic [7:0] status_register;
		logic [15:0] pc;
		logic [1:0] wait_cnt;
		logic [1:0] last_cycles;
		logic [31:0] prdata;
		logic slverr;
	} cssx_state_type;

endpackage

// [cssx_exec.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cssx_consts.svh"

module cssx_exec
	import cssx_pkg::*;
#(
	parameter int PC_W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction issue
	input wire logic issue_valid,
	input wire cssx_issue_type issue,
	output logic issue_ready,
	// Core state
	output logic [15:0] pc,
	output logic [7:0] status_register,
	output logic busy
);

	// The struct fixes the counter at 16 bits; other widths are refused
	if (PC_W != 16) begin : g_pc_w_check
		$error("cssx_exec: PC_W must be 16");
	end

	cssx_state_type state_reg; // Registered state
	cssx_state_type state_next; // Next state
	logic accept; // Instruction taken this cycle
	logic apb_setup; // APB setup phase
	logic apb_write; // APB write takes effect

	// Handshakes
	assign apb_setup = psel && !penable;
	assign pready = psel && penable;
	assign apb_write = pready && pwrite;
	assign busy = (state_reg.wait_cnt != 2'd0);
	// A skip or branch holds issue off for its extra cycles
	assign issue_ready = state_reg.enable && !busy;
	assign accept = issue_valid && issue_ready;

	// Outputs straight from state, except pslverr, which is gated by pready
	assign prdata = state_reg.prdata;
	assign pslverr = pready && state_reg.slverr;
	assign pc = state_reg.pc;
	assign status_register = state_reg.status_register;

	// Next-state logic: APB first, execution after so that it wins a same-cycle clash
	always_comb begin
		logic [7:0] diff;
		logic rd7;
		logic k7;
		logic taken;
		logic [1:0] cycles;
		diff = 8'h00;
		rd7 = 1'b0;
		k7 = 1'b0;
		taken = 1'b0;
		cycles = `CSSX_CYC_ONE;
		state_next = state_reg;

		// Read data latched in setup so it comes from a flip-flop in access
		if (apb_setup) begin
			state_next.slverr = 1'b0;
			unique case (paddr)
				`CSSX_OFS_CTRL: begin
					state_next.prdata = {31'h0000_0000, state_reg.enable};
				end
				`CSSX_OFS_STATUS: begin
					state_next.prdata = {24'h00_0000, state_reg.status_register};
				end
				`CSSX_OFS_PC: begin
					state_next.prdata = {16'h0000, state_reg.pc};
				end
				`CSSX_OFS_INFO: begin
					state_next.prdata = {29'h0000_0000, busy, state_reg.last_cycles};
				end
				default: begin
					// Unmapped: zero data and an error answer
					state_next.prdata = 32'h0000_0000;
					state_next.slverr = 1'b1;
				end
			endcase
		end

		// Register writes
		if (apb_write) begin
			unique case (paddr)
				`CSSX_OFS_CTRL: begin
					state_next.enable = pwdata[`CSSX_CTRL_ENABLE];
				end
				`CSSX_OFS_STATUS: begin
					state_next.status_register = pwdata[7:0];
				end
				`CSSX_OFS_PC: begin
					state_next.pc = pwdata[15:0];
				end
				default: begin
					// Read-only or unmapped: write ignored
				end
			endcase
		end

		// Extra cycles of a taken skip or branch run down here
		if (busy) begin
			state_next.wait_cnt = state_reg.wait_cnt - 2'd1;
		end

		// Execute the accepted instruction
		if (accept) begin
			state_next.pc = state_reg.pc + `CSSX_PC_STEP;
			unique case (issue.op)
				cssx_compare_immediate: begin
					// Subtract only; the result is never stored
					diff = issue.reg_value - issue.immediate;
					rd7 = issue.reg_value[7];
					k7 = issue.immediate[7];
					state_next.status_register[`CSSX_FLAG_Z] = (diff == 8'h00);
					state_next.status_register[`CSSX_FLAG_N] = diff[7];
					state_next.status_register[`CSSX_FLAG_V] =
						(rd7 && !k7 && !diff[7]) || (!rd7 && k7 && diff[7]);
					state_next.status_register[`CSSX_FLAG_C] =
						(!rd7 && k7) || (k7 && diff[7]) || (diff[7] && !rd7);
					state_next.status_register[`CSSX_FLAG_H] =
						(!issue.reg_value[3] && issue.immediate[3])
						|| (issue.immediate[3] && diff[3])
						|| (diff[3] && !issue.reg_value[3]);
				end
				cssx_skip_if_reg_bit_clear: begin
					taken = !issue.reg_value[issue.bit_sel];
				end
				cssx_skip_if_reg_bit_set: begin
					taken = issue.reg_value[issue.bit_sel];
				end
				cssx_skip_if_io_bit_clear: begin
					taken = !issue.io_value[issue.bit_sel];
				end
				cssx_skip_if_io_bit_set: begin
					taken = issue.io_value[issue.bit_sel];
				end
				cssx_branch_if_flag_set: begin
					taken = state_reg.status_register[issue.bit_sel];
				end
				cssx_branch_if_flag_clear: begin
					taken = !state_reg.status_register[issue.bit_sel];
				end
				default: begin
					// Unused class code: treated as a plain one-cycle step
				end
			endcase
			// Taken skips and branches leave the flags alone
			if (taken) begin
				if (issue.op == cssx_branch_if_flag_set || issue.op == cssx_branch_if_flag_clear) begin
					// Offset is sign-extended to the counter width
					state_next.pc = state_reg.pc + {{9{issue.offset[6]}}, issue.offset}
						+ `CSSX_PC_STEP;
					cycles = `CSSX_CYC_TWO;
				end else if (issue.next_two_word) begin
					state_next.pc = state_reg.pc + `CSSX_PC_SKIP2;
					cycles = `CSSX_CYC_THREE;
				end else begin
					state_next.pc = state_reg.pc + `CSSX_PC_SKIP1;
					cycles = `CSSX_CYC_TWO;
				end
			end
			state_next.wait_cnt = cycles - 2'd1;
			state_next.last_cycles = cycles;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.enable <= `CSSX_RST_ENABLE;
			state_reg.status_register <= `CSSX_RST_STATUS;
			state_reg.pc <= `CSSX_RST_PC;
			state_reg.wait_cnt <= 2'd0;
			state_reg.last_cycles <= 2'd0;
			state_reg.prdata <= 32'h0000_0000;
			state_reg.slverr <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Helper terms for the checks below
	logic acc_clean; // Accept with no APB write in the same cycle
	logic reg_bit; // Selected register bit
	logic io_bit; // Selected I/O bit
	logic flag_bit; // Selected status flag
	assign acc_clean = accept && !apb_write;
	assign reg_bit = issue.reg_value[issue.bit_sel];
	assign io_bit = issue.io_value[issue.bit_sel];
	assign flag_bit = status_register[issue.bit_sel];

	// One wait cycle then free again
	sequence s_one_wait;
		busy ##1 !busy;
	endsequence

	// Two wait cycles then free again
	sequence s_two_wait;
		busy [*2] ##1 !busy;
	endsequence

	property p_cmp_imm;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_compare_immediate |=>
			!busy && status_register[`CSSX_FLAG_Z] == ($past(issue.reg_value) == $past(issue.immediate))
			&& status_register[`CSSX_FLAG_C] == ($past(issue.reg_value) < $past(issue.immediate))
			&& pc == $past(pc) + 16'd1;
	endproperty
	a_cmp_imm: assert property (p_cmp_imm) else $error("compare immediate flags or timing wrong");

	property p_skip_reg_clr;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_reg_bit_clear && !reg_bit && !issue.next_two_word |=>
			pc == $past(pc) + 16'd2 && $stable(status_register) ##0 s_one_wait;
	endproperty
	a_skip_reg_clr: assert property (p_skip_reg_clr) else $error("register bit clear skip wrong");

	property p_skip_reg_set;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_reg_bit_set |=>
			pc == $past(pc) + ($past(reg_bit) ? ($past(issue.next_two_word) ? 16'd3 : 16'd2) : 16'd1);
	endproperty
	a_skip_reg_set: assert property (p_skip_reg_set) else $error("register bit set skip wrong");

	property p_skip_io_clr;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_io_bit_clear && io_bit |=> pc == $past(pc) + 16'd1 && !busy;
	endproperty
	a_skip_io_clr: assert property (p_skip_io_clr) else $error("I/O bit clear skip taken wrongly");

	property p_skip_io_set;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_io_bit_set && io_bit && !issue.next_two_word |=>
			pc == $past(pc) + 16'd2 ##0 s_one_wait;
	endproperty
	a_skip_io_set: assert property (p_skip_io_set) else $error("I/O bit set skip wrong");

	property p_br_set;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_branch_if_flag_set && flag_bit |=>
			pc == $past(pc) + {{9{$past(issue.offset[6])}}, $past(issue.offset)} + 16'd1
			&& $stable(status_register) ##0 s_one_wait;
	endproperty
	a_br_set: assert property (p_br_set) else $error("branch on flag set wrong");

	property p_br_clr;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_branch_if_flag_clear |=>
			pc == $past(pc) + ($past(flag_bit) ? 16'h0001
				: {{9{$past(issue.offset[6])}}, $past(issue.offset)} + 16'h0001)
			&& $stable(status_register);
	endproperty
	a_br_clr: assert property (p_br_clr) else $error("branch on flag clear wrong");

	property p_skip_two_word;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_reg_bit_clear && !reg_bit && issue.next_two_word |=>
			pc == $past(pc) + 16'd3 ##0 s_two_wait;
	endproperty
	a_skip_two_word: assert property (p_skip_two_word) else $error("two-word skip wrong");

	// A clear skip whose bit is set falls through in one cycle
	property p_skip_reg_clr_not;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_reg_bit_clear && reg_bit |=>
			pc == $past(pc) + 16'h0001 && !busy && $stable(status_register);
	endproperty
	a_skip_reg_clr_not: assert property (p_skip_reg_clr_not)
		else $error("register bit clear skip taken wrongly");

	// Set-bit skip never touches the flags; it stalls only when taken
	property p_skip_reg_set_flags;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_reg_bit_set |=>
			$stable(status_register) && busy == $past(reg_bit);
	endproperty
	a_skip_reg_set_flags: assert property (p_skip_reg_set_flags)
		else $error("register bit set skip flags or stall wrong");

	// Taken I/O clear skip over a one-word instruction
	property p_skip_io_clr_taken;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_io_bit_clear && !io_bit && !issue.next_two_word |=>
			pc == $past(pc) + 16'h0002 && $stable(status_register) ##0 s_one_wait;
	endproperty
	a_skip_io_clr_taken: assert property (p_skip_io_clr_taken)
		else $error("I/O bit clear skip not taken");

	// Taken I/O set skip over a two-word instruction
	property p_skip_io_set_two;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_skip_if_io_bit_set && io_bit && issue.next_two_word |=>
			pc == $past(pc) + 16'h0003 && $stable(status_register) ##0 s_two_wait;
	endproperty
	a_skip_io_set_two: assert property (p_skip_io_set_two)
		else $error("I/O bit set two-word skip wrong");

	// Branch on a clear flag that wants it set falls through at once
	property p_br_set_not;
		@(posedge pclk) disable iff (!presetn)
		acc_clean && issue.op == cssx_branch_if_flag_set && !flag_bit |=>
			pc == $past(pc) + 16'h0001 && !busy && $stable(status_register);
	endproperty
	a_br_set_not: assert property (p_br_set_not)
		else $error("branch on flag set taken wrongly");

	// Extra cycles are dead: nothing is issued, so counter and flags hold unless an APB write changes them
	property p_busy_hold;
		@(posedge pclk) disable iff (!presetn)
		busy && !apb_write |=> $stable(pc) && $stable(status_register);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("state moved during a stall cycle");

endmodule // cssx_exec
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cssx_consts.svh"

module tb_top
	import cssx_pkg::*;
;
	// Clock, reset and bus
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// Issue side and core state
	logic issue_valid, issue_ready, busy;
	cssx_issue_type issue, x;
	logic [15:0] pc, m_pc;
	logic [7:0] status_register, m_sr, r;
	logic [1:0] cy;
	logic t, acc, rdn;
	logic [31:0] rv;
	logic [32:0] rdv;
	// Expected notes, oldest first
	logic [24:0] q_core[$];
	logic [32:0] q_rd[$];
	int num_errors = 0, samples_checked = 0, cyc = 0, i;
	integer seed = 32'h4568_0f7a;

	cssx_exec #(.PC_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
		.pc(pc), .status_register(status_register), .busy(busy));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		// Notes never matched by a result count as mismatches
		num_errors += q_core.size() + q_rd.size();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmp_core(input logic [24:0] e, input logic [24:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected pc_status_busy exp %h got %h", e, s);
		end
	endtask

	task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected err_and_prdata exp %h got %h", e, s);
		end
	endtask

	// One APB transfer; starts an edge later so psel never toggles twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q_rd.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// Offer one instruction, note the result at the accepting edge
	task automatic iss();
		@(posedge pclk);
		issue_valid <= 1'b1;
		issue <= x;
		@(posedge pclk);
		while (!issue_ready) @(posedge pclk);
		q_core.push_back({m_pc, m_sr, cy != 2'd1});
		issue_valid <= 1'b0;
		@(posedge pclk);
		while (busy) @(posedge pclk);
	endtask

	// Watcher: catch results at the edge, compare half a cycle later when settled
	always @(posedge pclk) begin
		acc <= issue_valid & issue_ready;
		rdn <= psel & penable & pready & !pwrite;
		rdv <= {pslverr, prdata};
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	always @(negedge pclk) begin
		if (acc === 1'b1 && q_core.size() > 0)
			cmp_core(q_core.pop_front(), {pc, status_register, busy});
		if (rdn === 1'b1 && q_rd.size() > 0)
			cmp_rd(q_rd.pop_front(), rdv);
	end

	// Main sequence
	initial begin
		{psel, penable, pwrite, issue_valid} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		issue = '0;
		x = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		m_pc = 16'h0000;
		m_sr = 8'h00;
		// Reset values, read-only and unmapped places
		rd(`CSSX_OFS_CTRL, 33'h0_0000_0001);
		rd(`CSSX_OFS_STATUS, 33'h0_0000_0000);
		rd(`CSSX_OFS_PC, 33'h0_0000_0000);
		apb(1'b1, `CSSX_OFS_INFO, 32'hffff_ffff);
		rd(8'h10, 33'h1_0000_0000);
		apb(1'b1, `CSSX_OFS_CTRL, 32'h0000_0000);
		rd(`CSSX_OFS_CTRL, 33'h0_0000_0000);
		// Offered while disabled: must be refused, so the counter stays put
		issue_valid <= 1'b1;
		repeat (3) @(posedge pclk);
		issue_valid <= 1'b0;
		rd(`CSSX_OFS_PC, 33'h0_0000_0000);
		apb(1'b1, `CSSX_OFS_CTRL, 32'h0000_0001);
		rv = $random(seed);
		m_pc = rv[15:0];
		apb(1'b1, `CSSX_OFS_PC, {16'hffff, m_pc});
		rd(`CSSX_OFS_PC, {17'h0_0000, m_pc});
		// Every instruction kind in turn, random operands
		for (i = 0; i < 140; i++) begin
			x.op = cssx_op_type'(i % 7);
			rv = $random(seed);
			{x.reg_value, x.immediate, x.io_value} = rv[23:0];
			rv = $random(seed);
			{x.bit_sel, x.offset, x.next_two_word} = rv[10:0];
			if (i % 5 == 0) begin
				rv = $random(seed);
				m_sr = rv[7:0];
				apb(1'b1, `CSSX_OFS_STATUS, {24'h00_0000, m_sr});
			end
			case (x.op)
				cssx_skip_if_reg_bit_clear: t = !x.reg_value[x.bit_sel];
				cssx_skip_if_reg_bit_set: t = x.reg_value[x.bit_sel];
				cssx_skip_if_io_bit_clear: t = !x.io_value[x.bit_sel];
				cssx_skip_if_io_bit_set: t = x.io_value[x.bit_sel];
				cssx_branch_if_flag_set: t = m_sr[x.bit_sel];
				default: t = !m_sr[x.bit_sel];
			endcase
			if (x.op == cssx_compare_immediate) begin
				// Flags from the plain arithmetic meaning: borrows and signed overflow
				r = x.reg_value - x.immediate;
				m_sr[`CSSX_FLAG_C] = (x.reg_value < x.immediate);
				m_sr[`CSSX_FLAG_Z] = (r == 8'h00);
				m_sr[`CSSX_FLAG_N] = r[7];
				m_sr[`CSSX_FLAG_V] = (x.reg_value[7] != x.immediate[7])
					&& (r[7] != x.reg_value[7]);
				m_sr[`CSSX_FLAG_H] = (x.reg_value[3:0] < x.immediate[3:0]);
				cy = 2'd1;
				m_pc = m_pc + 16'h0001;
			end else if (x.op >= cssx_branch_if_flag_set) begin
				cy = t ? 2'd2 : 2'd1;
				m_pc = m_pc + 16'h0001 + (t ? {{9{x.offset[6]}}, x.offset} : 16'h0000);
			end else begin
				cy = !t ? 2'd1 : (x.next_two_word ? 2'd3 : 2'd2);
				m_pc = m_pc + {14'h0000, cy};
			end
			iss();
			rd(`CSSX_OFS_INFO, {31'h0000_0000, cy});
		end
		repeat (4) @(posedge pclk);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
